// [psir_pkg.sv]
// Shared constants for the Link_state_report and interrupt register block.
// Assumes a management frame engine that issues single-cycle register reads/writes.
package psir_pkg;
  localparam logic [4:0]  PSIR_ADDR_STATUS = 5'h11;  // Live link state report
  localparam logic [4:0]  PSIR_ADDR_MASK   = 5'h12;  // Interrupt enable mask
  localparam logic [4:0]  PSIR_ADDR_EVENT  = 5'h13;  // Event status
  localparam logic [15:0] PSIR_MASK_RST    = 16'h0000;
  localparam logic [15:0] PSIR_EVENT_RST   = 16'h0000;
  // Event bits that latch high and clear on read (bit 1 latches, see rules)
  localparam logic [15:0] PSIR_LATCH_BITS  = 16'hFDF3;
  // Event bits that simply follow their source level
  localparam logic [15:0] PSIR_LIVE_BITS   = 16'h020C;
  localparam int          PSIR_POS_SPEED   = 14;
  localparam int          PSIR_POS_DUPLEX  = 13;
  localparam int          PSIR_POS_PAGE    = 12;
  localparam int          PSIR_POS_RESOLV  = 11;
  localparam int          PSIR_POS_LINK    = 10;
  localparam int          PSIR_POS_XOVCD   = 9;
  localparam int          PSIR_POS_XOVAB   = 8;
  localparam int          PSIR_POS_DNSHIFT = 7;
  localparam int          PSIR_POS_SLEEP   = 6;
  localparam int          PSIR_POS_PAIRPOL = 2;
  localparam int          PSIR_POS_POL10   = 1;
  localparam int          PSIR_POS_JABBER  = 0;
  localparam logic [1:0]  PSIR_SPEED_10    = 2'h0;
  localparam logic [1:0]  PSIR_SPEED_100   = 2'h1;
  localparam logic [1:0]  PSIR_SPEED_1000  = 2'h2;
  localparam logic        PSIR_INT_POL_RST = 1'h1;   // Active-low pin after reset
endpackage

// [psir_regs.sv]
// Status report, interrupt enable mask and event status registers.
// Assumes sources are synchronous to clk_sys except where marked as pins.
`timescale 1ns/1ps
module psir_regs
  import psir_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // Management register access
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_hit,
  // Live status sources
  input  wire logic [1:0]  resolved_speed,
  input  wire logic        resolved_duplex,
  input  wire logic        page_arrived,
  input  wire logic        negotiation_resolved,
  input  wire logic        link_up,
  input  wire logic        crossover_pairs_cd,
  input  wire logic        crossover_pairs_ab,
  input  wire logic        downshift_active,
  input  wire logic        sleep_active,
  input  wire logic [3:0]  pair_polarity_rev,
  input  wire logic        polarity_10m_normal,
  input  wire logic        jabber_present,
  // Event pulses, one bit per event status position
  input  wire logic [15:0] event_pulse,
  // Interrupt polarity from the neighbouring configuration register
  input  wire logic        int_active_low,
  // Interrupt pin level
  output logic             int_pin
);
  import psir_pkg::*;

  logic [15:0] mask_reg;      // Enable mask
  logic [15:0] event_reg;     // Latched events
  logic        page_reg;      // Latched page-received status
  logic [15:0] status_word;   // Live status assembly
  logic [15:0] event_word;    // Event register as read
  logic        rd_status;     // Read of status register
  logic        rd_event;      // Read of event register
  logic        int_any;       // Interrupt condition, polarity-free

  assign rd_status = reg_rd && (reg_addr == PSIR_ADDR_STATUS);
  assign rd_event  = reg_rd && (reg_addr == PSIR_ADDR_EVENT);

  // Assemble the live report word
  always_comb begin
    status_word = 16'h0000;
    status_word[PSIR_POS_SPEED +: 2]   = resolved_speed;
    status_word[PSIR_POS_DUPLEX]       = resolved_duplex;
    status_word[PSIR_POS_PAGE]         = page_reg;
    status_word[PSIR_POS_RESOLV]       = negotiation_resolved;
    status_word[PSIR_POS_LINK]         = link_up;
    status_word[PSIR_POS_XOVCD]        = crossover_pairs_cd;
    status_word[PSIR_POS_XOVAB]        = crossover_pairs_ab;
    // Only meaningful while negotiating; source is trusted to gate it
    status_word[PSIR_POS_DNSHIFT]      = downshift_active;
    status_word[PSIR_POS_SLEEP]        = sleep_active;
    status_word[PSIR_POS_PAIRPOL +: 4] = pair_polarity_rev;
    status_word[PSIR_POS_POL10]        = polarity_10m_normal;
    status_word[PSIR_POS_JABBER]       = jabber_present;
  end

  // Live bits show their source; latched bits show the sticky flops
  assign event_word = (event_reg & PSIR_LATCH_BITS) | (event_pulse & PSIR_LIVE_BITS);

  // Page-received latch: set wins over the read clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      page_reg <= 1'b0;
    end else if (clk_en) begin
      if (page_arrived) begin
        page_reg <= 1'b1;
      end else if (rd_status) begin
        page_reg <= 1'b0;
      end
    end
  end

  // Enable mask, plain read/write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= PSIR_MASK_RST;
    end else if (clk_en && reg_wr && (reg_addr == PSIR_ADDR_MASK)) begin
      mask_reg <= reg_wdata;
    end
  end

  // Sticky events; recorded whatever the mask says, an arriving event survives the clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_reg <= PSIR_EVENT_RST;
    end else if (clk_en) begin
      event_reg <= ((rd_event ? 16'h0000 : event_reg) | event_pulse) & PSIR_LATCH_BITS;
    end
  end

  // Interrupt condition and pin polarity
  assign int_any = |(event_word & mask_reg);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_pin <= PSIR_INT_POL_RST ? 1'b1 : 1'b0;
    end else if (clk_en) begin
      int_pin <= int_active_low ? ~int_any : int_any;
    end
  end

  // Read data, registered; unmapped addresses return zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
      reg_hit   <= 1'b0;
    end else if (clk_en) begin
      reg_hit <= reg_rd && (reg_addr == PSIR_ADDR_STATUS || reg_addr == PSIR_ADDR_MASK ||
                            reg_addr == PSIR_ADDR_EVENT);
      case (reg_addr)
        PSIR_ADDR_STATUS: reg_rdata <= reg_rd ? status_word : 16'h0000;
        PSIR_ADDR_MASK:   reg_rdata <= reg_rd ? mask_reg : 16'h0000;
        PSIR_ADDR_EVENT:  reg_rdata <= reg_rd ? event_word : 16'h0000;
        default:          reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Checks
  property p_evt_set;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && event_pulse[15]) |=> event_reg[15];
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("latched event lost");
  property p_evt_clr;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && rd_event && !event_pulse[0]) |=> !event_reg[0];
  endproperty
  a_evt_clr: assert property (p_evt_clr) else $error("read did not clear");
  property p_mask_rst;
    @(posedge clk_sys) disable iff (!arst_n)
      (mask_reg == 16'h0000) && clk_en |=> (int_pin == int_active_low) || $changed(int_active_low);
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("interrupt with empty mask");
  property p_int_on;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && int_any) |=> (int_pin == ~$past(int_active_low));
  endproperty
  a_int_on: assert property (p_int_on) else $error("interrupt polarity wrong");
  property p_page;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && page_arrived) |=> page_reg;
  endproperty
  a_page: assert property (p_page) else $error("page latch missed");
  property p_live;
    @(posedge clk_sys) disable iff (!arst_n) event_word[9] == event_pulse[9];
  endproperty
  a_live: assert property (p_live) else $error("live bit wrong");
  property p_record;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && event_pulse[4] && !mask_reg[4]) |=> event_reg[4];
  endproperty
  a_record: assert property (p_record) else $error("masked event not recorded");
  property p_wr;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && reg_wr && reg_addr == PSIR_ADDR_MASK) |=> mask_reg == $past(reg_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("mask write lost");

  // Named request steps shared by the checks below
  // A taken read of the live report word
  sequence s_rd_status;
    clk_en && rd_status;
  endsequence
  // A taken read of the event word
  sequence s_rd_event;
    clk_en && rd_event;
  endsequence
  // A taken read of the event word while the jabber event arrives
  sequence s_rd_and_set;
    clk_en && rd_event && event_pulse[PSIR_POS_JABBER];
  endsequence
  // A taken write aimed at the enable mask
  sequence s_wr_mask;
    clk_en && reg_wr && (reg_addr == PSIR_ADDR_MASK);
  endsequence

  // Enable low must freeze the event, mask, page and read-data flops
  // A leak here would let events slip in while the engine is stalled
  property p_freeze;
    @(posedge clk_sys) disable iff (!arst_n)
      !clk_en |=> $stable(event_reg) && $stable(mask_reg) && $stable(page_reg) && $stable(reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  // Speed field read back as sampled on the request edge
  property p_rd_speed;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[15:14] == $past(resolved_speed);
  endproperty
  a_rd_speed: assert property (p_rd_speed) else $error("speed field wrong");

  // Duplex bit read back
  property p_rd_duplex;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[13] == $past(resolved_duplex);
  endproperty
  a_rd_duplex: assert property (p_rd_duplex) else $error("duplex bit wrong");

  // Resolved bit read back
  property p_rd_resolv;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[11] == $past(negotiation_resolved);
  endproperty
  a_rd_resolv: assert property (p_rd_resolv) else $error("resolved bit wrong");

  // Link bit read back
  property p_rd_link;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[10] == $past(link_up);
  endproperty
  a_rd_link: assert property (p_rd_link) else $error("link bit wrong");

  // Downshift bit read back; gating by negotiation is the source's job
  property p_rd_dnshift;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[7] == $past(downshift_active);
  endproperty
  a_rd_dnshift: assert property (p_rd_dnshift) else $error("downshift bit wrong");

  // Sleep bit read back
  property p_rd_sleep;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[6] == $past(sleep_active);
  endproperty
  a_rd_sleep: assert property (p_rd_sleep) else $error("sleep bit wrong");

  // Pair polarity nibble keeps D in the top bit
  property p_rd_pairpol;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[5:2] == $past(pair_polarity_rev);
  endproperty
  a_rd_pairpol: assert property (p_rd_pairpol) else $error("pair polarity wrong");

  // 10M polarity bit is one for normal, no inversion on the way
  property p_rd_pol10;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[1] == $past(polarity_10m_normal);
  endproperty
  a_rd_pol10: assert property (p_rd_pol10) else $error("10M polarity wrong");

  // Jabber level in the lowest report bit
  property p_rd_jabber;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_status |=> reg_rdata[0] == $past(jabber_present);
  endproperty
  a_rd_jabber: assert property (p_rd_jabber) else $error("jabber bit wrong");

  // Status read with no new page clears the page latch
  property p_page_clr;
    @(posedge clk_sys) disable iff (!arst_n)
      (s_rd_status and !page_arrived) |=> !page_reg;
  endproperty
  a_page_clr: assert property (p_page_clr) else $error("page latch not cleared");

  // No enabled cause means the pin sits at its idle level
  property p_int_off;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && !int_any) |=> (int_pin == $past(int_active_low));
  endproperty
  a_int_off: assert property (p_int_off) else $error("interrupt without cause");

  // An event arriving with the clearing read must survive it
  property p_survive;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_and_set |=> event_reg[PSIR_POS_JABBER];
  endproperty
  a_survive: assert property (p_survive) else $error("event lost to read clear");

  // Latched events stay put until the event word is read
  property p_evt_hold;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && !rd_event && event_reg[10]) |=> event_reg[10];
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("latched event dropped");

  // Live positions never hold a sticky copy
  property p_no_latch_live;
    @(posedge clk_sys) disable iff (!arst_n)
      (event_reg & PSIR_LIVE_BITS) == 16'h0000;
  endproperty
  a_no_latch_live: assert property (p_no_latch_live) else $error("live bit latched");

  // Polarity change latches like the jabber bit below it
  property p_bit1;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && event_pulse[1]) |=> event_reg[1];
  endproperty
  a_bit1: assert property (p_bit1) else $error("polarity change not latched");

  // Middle latched group, checked at its top position
  property p_bit8;
    @(posedge clk_sys) disable iff (!arst_n)
      (clk_en && event_pulse[8]) |=> event_reg[8];
  endproperty
  a_bit8: assert property (p_bit8) else $error("bit 8 event not latched");

  // Mask changes only through a write to its own address
  property p_mask_hold;
    @(posedge clk_sys) disable iff (!arst_n)
      !(clk_en && reg_wr && (reg_addr == PSIR_ADDR_MASK)) |=> $stable(mask_reg);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

  // Mask write is visible on the following read
  property p_mask_readback;
    @(posedge clk_sys) disable iff (!arst_n)
      s_wr_mask ##1 (clk_en && reg_rd && reg_addr == PSIR_ADDR_MASK && !reg_wr) |=> reg_rdata == $past(mask_reg);
  endproperty
  a_mask_readback: assert property (p_mask_readback) else $error("mask read back wrong");

  // Event read returns the pre-clear word and flags a hit
  property p_rd_event;
    @(posedge clk_sys) disable iff (!arst_n)
      s_rd_event |=> (reg_rdata == $past(event_word)) && reg_hit;
  endproperty
  a_rd_event: assert property (p_rd_event) else $error("event read data wrong");
endmodule

// [psir_mgmt_model.sv]
// Management controller model: single-cycle register reads and writes.
// Assumes the register block answers one cycle after the request edge.
`timescale 1ns/1ps
module psir_mgmt_model (
  // Clock
  input  wire logic        clk_sys,
  // Register access
  output logic      [4:0]  reg_addr,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_hit
);
  // Idle bus at time zero
  initial begin
    reg_addr = 5'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One request edge; released address and write data show the inverse so stale values never look valid
  task automatic xfer(input logic [4:0] a, input logic [15:0] wd, input logic is_wr,
                      output logic [15:0] rd, output logic hit);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = wd;
    reg_wr = is_wr;
    reg_rd = ~is_wr;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~wd;
    rd = reg_rdata;
    hit = reg_hit;
  endtask
endmodule

// [psir_regs_tb.sv]
// Self-checking bench for the status and interrupt register block.
// Assumes registered read data one cycle after the request edge.
`timescale 1ns/1ps
module psir_regs_tb;
  import psir_pkg::*;
  logic        clk_sys, arst_n, clk_en, page, pol, rd, wr, hit, int_pin;
  logic [4:0]  addr;
  logic [15:0] st, ev, wd, rdata;
  int          fail_count, checks_done;
  // Live status words; each drives the status inputs and is the expected report
  logic [15:0] rows [12] = '{16'h4000, 16'h8000, 16'h2000, 16'h0800, 16'h0400, 16'h0200,
                             16'h0100, 16'h0080, 16'h0040, 16'h0024, 16'h0002, 16'h0001};
  psir_regs u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(addr),
    .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdata), .reg_hit(hit),
    .resolved_speed(st[15:14]), .resolved_duplex(st[13]), .page_arrived(page),
    .negotiation_resolved(st[11]), .link_up(st[10]), .crossover_pairs_cd(st[9]),
    .crossover_pairs_ab(st[8]), .downshift_active(st[7]), .sleep_active(st[6]),
    .pair_polarity_rev(st[5:2]), .polarity_10m_normal(st[1]), .jabber_present(st[0]),
    .event_pulse(ev), .int_active_low(pol), .int_pin(int_pin));
  psir_mgmt_model m (.clk_sys(clk_sys), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wd), .reg_rdata(rdata), .reg_hit(hit));
  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Read and compare data and hit flag
  task automatic rchk(input logic [4:0] a, input logic [15:0] e, input logic eh);
    logic [15:0] d;
    logic        h;
    m.xfer(a, 16'h0000, 1'b0, d, h);
    chk(d, e);
    chk({15'h0, h}, {15'h0, eh});
  endtask
  task automatic pulse(input logic [15:0] v);
    @(posedge clk_sys);
    #1 ev = v;
    @(posedge clk_sys);
    #1 ev = 16'h0000;
  endtask
  // Bounded wait on the pin; running out ends the run
  task automatic wait_int(input logic v);
    int n;
    n = 0;
    while (int_pin !== v && n < 4) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk({15'h0, int_pin}, {15'h0, v});
    if (n == 4) begin
      test_done();
    end
  endtask
  // Hang guard
  initial begin
    #500000 fail_count++;
    test_done();
  end
  initial begin : main
    logic [15:0] d;
    logic        h;
    {clk_sys, arst_n, page, pol, clk_en, st, ev} = {4'h1, 1'b1, 32'h0};
    repeat (16) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    chk({15'h0, int_pin}, 16'h0001);
    rchk(PSIR_ADDR_MASK, PSIR_MASK_RST, 1'b1);
    rchk(PSIR_ADDR_EVENT, PSIR_EVENT_RST, 1'b1);
    rchk(5'h14, 16'h0000, 1'b0);
    for (int i = 0; i < 12; i++) begin
      st = rows[i];
      rchk(PSIR_ADDR_STATUS, rows[i], 1'b1);
    end
    st = 16'h0000;
    @(posedge clk_sys);
    #1 page = 1'b1;
    @(posedge clk_sys);
    #1 page = 1'b0;
    rchk(PSIR_ADDR_STATUS, 16'h1000, 1'b1);
    rchk(PSIR_ADDR_STATUS, 16'h0000, 1'b1);
    // All latching events with every enable clear
    pulse(16'hFDF3);
    repeat (2) @(posedge clk_sys);
    chk({15'h0, int_pin}, 16'h0001);
    rchk(PSIR_ADDR_EVENT, 16'hFDF3, 1'b1);
    rchk(PSIR_ADDR_EVENT, 16'h0000, 1'b1);
    ev = 16'h020C;
    rchk(PSIR_ADDR_EVENT, 16'h020C, 1'b1);
    rchk(PSIR_ADDR_EVENT, 16'h020C, 1'b1);
    ev = 16'h0000;
    m.xfer(PSIR_ADDR_EVENT, 16'hFFFF, 1'b1, d, h);
    m.xfer(PSIR_ADDR_MASK, 16'h0001, 1'b1, d, h);
    rchk(PSIR_ADDR_MASK, 16'h0001, 1'b1);
    rchk(PSIR_ADDR_EVENT, 16'h0000, 1'b1);
    pulse(16'h0002);
    repeat (2) @(posedge clk_sys);
    chk({15'h0, int_pin}, 16'h0001);
    pulse(16'h0001);
    wait_int(1'b0);
    rchk(PSIR_ADDR_EVENT, 16'h0003, 1'b1);
    wait_int(1'b1);
    pol = 1'b0;
    wait_int(1'b0);
    // Event landing on the clearing read must survive it
    fork
      m.xfer(PSIR_ADDR_EVENT, 16'h0000, 1'b0, d, h);
      pulse(16'h0001);
    join
    wait_int(1'b1);
    rchk(PSIR_ADDR_EVENT, 16'h0001, 1'b1);
    // Second reset in mid-run clears the enables
    pol = 1'b1;
    arst_n = 1'b0;
    @(posedge clk_sys);
    #1 arst_n = 1'b1;
    rchk(PSIR_ADDR_MASK, 16'h0000, 1'b1);
    // Enable low freezes the event latch
    clk_en = 1'b0;
    pulse(16'h0001);
    clk_en = 1'b1;
    rchk(PSIR_ADDR_EVENT, 16'h0000, 1'b1);
    test_done();
  end
endmodule
